// ===== rtl/lbs_pkg.sv
// Constants, register map and types of the layer blend and scroll engine.
// How it works
// - Blending happens only while the layer order code is 00b or 10b.
// - Four separately enabled key colours, each with an eighth-step blend ratio.
// - Mode bit 7 clear blends the overlay pixel under a main key colour.
// - A transparent matching top overlay makes the blend use the bottom overlay.
// - Key enables in control bits 8-11, four ratio nibbles, four key registers.
// - An overlay pixel equal to its transparent key shows the layer below.
// - Overlay transparency enables are control bits 1 and 2, each with a key.
// - Scroll wrapping exists for the primary base window and both overlay windows.
// - Reads begin at display start and wrap from scroll end to scroll start.
// - Wrapping applies to display reads only, never to host image writes.
// - Each scrolling window keeps start, end and display start over a register pair.
package lbs_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [15:0] OFS_ORDER = 16'h0202;
	localparam logic [15:0] OFS_CTRL  = 16'h0204;
	localparam logic [15:0] OFS_RATIO = 16'h0208;
	localparam logic [15:0] OFS_TKEY1 = 16'h020c;
	localparam logic [15:0] OFS_TKEY2 = 16'h020e;
	localparam logic [15:0] OFS_KEY1  = 16'h0210;
	localparam logic [15:0] OFS_KEY2  = 16'h0212;
	localparam logic [15:0] OFS_KEY3  = 16'h0214;
	localparam logic [15:0] OFS_KEY4  = 16'h0216;
	localparam logic [15:0] OFS_PAIR_HI = 16'h0002;
	// Window 0 is the primary base window, 1 and 2 the first and second overlay windows.
	localparam logic [15:0] OFS_SCR_START [3] = '{16'h0238, 16'h0270, 16'h02b0};
	localparam logic [15:0] OFS_SCR_END   [3] = '{16'h023c, 16'h0274, 16'h02b4};
	localparam logic [15:0] OFS_DISP      [3] = '{16'h0240, 16'h0278, 16'h02b8};

	// ------------------------------------------------------------
	// Field positions and widths
	// ------------------------------------------------------------
	localparam int ORDER_LSB     = 5;
	localparam int CTRL_TR1_BIT  = 1;
	localparam int CTRL_TR2_BIT  = 2;
	localparam int CTRL_MODE_BIT = 7;
	localparam int CTRL_KEN_LSB  = 8;
	localparam int NUM_KEYS      = 4;
	localparam int NUM_SCR       = 3;
	localparam int ADDR_W        = 20;
	localparam int PIX_W         = 16;
	localparam int FIFO_DEPTH    = 8;
	localparam logic [15:0] ADDR_LO_MASK = 16'hfffe;
	localparam logic [3:0]  RATIO_FULL   = 4'h8;
	localparam logic [1:0]  ORDER_MAIN_TOP_A = 2'h0;
	localparam logic [1:0]  ORDER_MAIN_TOP_B = 2'h2;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [1:0]         RST_ORDER   = 2'h0;
	localparam logic [15:0]        RST_REG16   = 16'h0000;
	localparam logic [ADDR_W-1:0]  RST_SCR_START = 20'h00000;
	localparam logic [ADDR_W-1:0]  RST_SCR_END   = 20'hffffe;
	localparam logic [ADDR_W-1:0]  RST_DISP      = 20'h00000;

	typedef logic [ADDR_W-1:0] lbs_addr_t;
	typedef logic [PIX_W-1:0]  lbs_pix_t;

endpackage

// ===== rtl/lbs_fifo_if.sv
// Valid and ready carrier for the output pixel buffer.
interface lbs_fifo_if #(parameter int W = 16);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;
	modport src  (output in_valid, output in_data, input in_ready);
	modport fifo (input in_valid, input in_data, output in_ready, output out_valid, output out_data, input out_ready);
	modport snk  (input out_valid, input out_data, output out_ready);
endinterface

// ===== rtl/lbs_fifo.sv
// Pixel buffer with registered full and empty flags and a registered head word.
module lbs_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	input wire logic clk,       // System clock.
	input wire logic rstn,      // Asynchronous reset, active low.
	lbs_fifo_if.fifo f          // Fill and drain sides.
);
	localparam int AW = $clog2(D);
	typedef logic [AW:0]   lbs_cnt_t;
	typedef logic [AW-1:0] lbs_ptr_t;

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		lbs_ptr_t            wr;
		lbs_ptr_t            rd;
		lbs_cnt_t            count;
		logic                in_rdy;
		logic                out_vld;
		logic [W-1:0]        head;
	} lbs_fifo_s;

	lbs_fifo_s s_q;
	lbs_fifo_s s_d;
	logic      push;
	logic      pop;

	assign push        = f.in_valid && s_q.in_rdy;
	assign pop         = s_q.out_vld && f.out_ready;
	assign f.in_ready  = s_q.in_rdy;
	assign f.out_valid = s_q.out_vld;
	assign f.out_data  = s_q.head;

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wr] = f.in_data;
			s_d.wr = (s_q.wr == lbs_ptr_t'(D - 1)) ? '0 : s_q.wr + lbs_ptr_t'(1);
		end
		if (pop) begin
			s_d.rd = (s_q.rd == lbs_ptr_t'(D - 1)) ? '0 : s_q.rd + lbs_ptr_t'(1);
		end
		s_d.count   = s_q.count + lbs_cnt_t'(push) - lbs_cnt_t'(pop);
		s_d.in_rdy  = s_d.count < lbs_cnt_t'(D);
		s_d.out_vld = s_d.count != '0;
		s_d.head    = s_d.mem[s_d.rd];
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{mem: '0, wr: '0, rd: '0, count: '0, in_rdy: 1'b1, out_vld: 1'b0, head: '0};
		end else begin
			s_q <= s_d;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	a_fifo_full_stall: assert property (!s_q.in_rdy |=> s_q.wr == $past(s_q.wr))
		else $error("fifo accepts data while full");
	a_fifo_empty_flag: assert property (!s_q.out_vld |=> s_q.rd == $past(s_q.rd))
		else $error("fifo drains data while empty");
endmodule

// ===== rtl/lbs_top.sv
// Layer blend, transparency and scroll wrap engine with its register set.
module lbs_top
	import lbs_pkg::*;
(
	input  wire logic                         CLK,            // System clock, 250 MHz.
	input  wire logic                         RSTN,           // Asynchronous reset, active low.
	input  wire logic [15:0]                  REG_ADDR,       // Register byte address.
	input  wire logic [15:0]                  REG_WDATA,      // Register write data.
	input  wire logic                         REG_WE,         // Register write strobe.
	input  wire logic                         REG_RE,         // Register read strobe.
	output      logic [15:0]                  REG_RDATA,      // Read data, one cycle after the strobe.
	input  wire logic                         PIX_IN_VALID,   // Input pixel set valid.
	output      logic                         PIX_IN_READY,   // Engine can take a pixel set.
	input  wire logic [15:0]                  PIX_MAIN,       // Main layer pixel, RGB565.
	input  wire logic [15:0]                  PIX_OV1,        // First overlay window pixel.
	input  wire logic [15:0]                  PIX_OV2,        // Second overlay window pixel.
	input  wire logic                         PIX_OV1_HIT,    // Position lies inside the first overlay window.
	input  wire logic                         PIX_OV2_HIT,    // Position lies inside the second overlay window.
	output      logic                         PIX_OUT_VALID,  // Composed pixel valid.
	input  wire logic                         PIX_OUT_READY,  // Panel path takes the pixel.
	output      logic [15:0]                  PIX_OUT,        // Composed pixel, RGB565.
	input  wire logic [NUM_SCR-1:0]           RD_FRAME,       // Per window: restart reads at display start.
	input  wire logic [NUM_SCR-1:0]           RD_ADV,         // Per window: advance the read address.
	input  wire logic [15:0]                  RD_STEP,        // Byte step of one advance.
	output      logic [NUM_SCR-1:0][ADDR_W-1:0] RD_ADDR       // Per window display read address.
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0]                     order;
		logic [15:0]                    ctrl;
		logic [15:0]                    ratio;
		logic [1:0][15:0]               tkey;
		logic [NUM_KEYS-1:0][15:0]      key;
		logic [NUM_SCR-1:0][ADDR_W-1:0] scr_start;
		logic [NUM_SCR-1:0][ADDR_W-1:0] scr_end;
		logic [NUM_SCR-1:0][ADDR_W-1:0] disp;
		logic [NUM_SCR-1:0][ADDR_W-1:0] rd_addr;
		logic [15:0]                    rdata;
	} lbs_state_s;

	lbs_state_s s_q;
	lbs_state_s s_d;

	lbs_fifo_if #(.W(PIX_W)) fq ();

	lbs_fifo #(.W(PIX_W), .D(FIFO_DEPTH)) u_fifo (
		.clk  (CLK),
		.rstn (RSTN),
		.f    (fq)
	);

	// ------------------------------------------------------------
	// Blend arithmetic
	// ------------------------------------------------------------
	function automatic logic [5:0] lbs_mix(input logic [5:0] m, input logic [5:0] p, input logic [3:0] r);
		logic [9:0] acc;
		acc = 10'(m) * 10'(r) + 10'(p) * 10'(RATIO_FULL - r);
		return acc[8:3];
	endfunction

	function automatic lbs_pix_t lbs_blend(input lbs_pix_t m, input lbs_pix_t p, input logic [3:0] r);
		logic [5:0] rc;
		logic [5:0] gc;
		logic [5:0] bc;
		rc = lbs_mix({1'b0, m[15:11]}, {1'b0, p[15:11]}, r);
		gc = lbs_mix(m[10:5], p[10:5], r);
		bc = lbs_mix({1'b0, m[4:0]}, {1'b0, p[4:0]}, r);
		return {rc[4:0], gc, bc[4:0]};
	endfunction

	// ------------------------------------------------------------
	// Composition
	// ------------------------------------------------------------
	logic [NUM_KEYS-1:0] key_hit;
	logic                ov1_clear;
	logic                ov2_clear;
	logic                ov1_top;
	logic                top_cov;
	logic                bot_cov;
	lbs_pix_t            top_pix;
	lbs_pix_t            bot_pix;
	lbs_pix_t            ov_pix;
	logic                ov_any;
	logic                sel_top;
	logic                main_top;
	logic                blend_sel;
	logic [1:0]          hit_idx;
	logic [3:0]          ratio_raw;
	logic [3:0]          ratio_eff;
	lbs_pix_t            comp_pix;

	genvar k;
	generate
		for (k = 0; k < NUM_KEYS; k++) begin : g_key
			assign key_hit[k] = s_q.ctrl[CTRL_KEN_LSB + k] && (PIX_MAIN == s_q.key[k]);
		end
	endgenerate

	always_comb begin
		// Transparent overlay pixels drop out of coverage, so the layer beneath wins.
		ov1_clear = s_q.ctrl[CTRL_TR1_BIT] && (PIX_OV1 == s_q.tkey[0]);
		ov2_clear = s_q.ctrl[CTRL_TR2_BIT] && (PIX_OV2 == s_q.tkey[1]);
		ov1_top   = s_q.order[1];
		top_cov   = ov1_top ? (PIX_OV1_HIT && !ov1_clear) : (PIX_OV2_HIT && !ov2_clear);
		bot_cov   = ov1_top ? (PIX_OV2_HIT && !ov2_clear) : (PIX_OV1_HIT && !ov1_clear);
		top_pix   = ov1_top ? PIX_OV1 : PIX_OV2;
		bot_pix   = ov1_top ? PIX_OV2 : PIX_OV1;
		sel_top   = top_cov;
		ov_any    = top_cov || bot_cov;
		ov_pix    = sel_top ? top_pix : bot_pix;
		main_top  = (s_q.order == ORDER_MAIN_TOP_A) || (s_q.order == ORDER_MAIN_TOP_B);
		// Scan from the highest key down so the lowest numbered match is kept.
		hit_idx   = 2'h0;
		for (int i = NUM_KEYS - 1; i >= 0; i--) begin
			if (key_hit[i]) begin
				hit_idx = 2'(i);
			end
		end
		ratio_raw = s_q.ratio[4*hit_idx +: 4];
		ratio_eff = (ratio_raw > RATIO_FULL) ? RATIO_FULL : ratio_raw;
		// Blending needs the main layer on top, the mode bit clear, a key match and an overlay.
		blend_sel = main_top && !s_q.ctrl[CTRL_MODE_BIT] && (key_hit != '0) && ov_any;
		if (blend_sel) begin
			comp_pix = lbs_blend(PIX_MAIN, ov_pix, ratio_eff);
		end else if (main_top || !ov_any) begin
			comp_pix = PIX_MAIN;
		end else begin
			comp_pix = ov_pix;
		end
	end

	assign fq.in_valid  = PIX_IN_VALID;
	assign fq.in_data   = comp_pix;
	assign fq.out_ready = PIX_OUT_READY;
	assign PIX_IN_READY  = fq.in_ready;
	assign PIX_OUT_VALID = fq.out_valid;
	assign PIX_OUT       = fq.out_data;
	assign REG_RDATA     = s_q.rdata;
	assign RD_ADDR       = s_q.rd_addr;

	// ------------------------------------------------------------
	// Registers and scroll address walk
	// ------------------------------------------------------------
	logic [ADDR_W:0] sum [NUM_SCR];

	always_comb begin
		s_d = s_q;
		for (int w = 0; w < NUM_SCR; w++) begin
			sum[w] = {1'b0, s_q.rd_addr[w]} + (ADDR_W + 1)'(RD_STEP);
		end
		if (REG_WE) begin
			unique case (REG_ADDR)
				OFS_ORDER: s_d.order = REG_WDATA[ORDER_LSB +: 2];
				OFS_CTRL:  s_d.ctrl = REG_WDATA;
				OFS_RATIO: s_d.ratio = REG_WDATA;
				OFS_TKEY1: s_d.tkey[0] = REG_WDATA;
				OFS_TKEY2: s_d.tkey[1] = REG_WDATA;
				OFS_KEY1:  s_d.key[0] = REG_WDATA;
				OFS_KEY2:  s_d.key[1] = REG_WDATA;
				OFS_KEY3:  s_d.key[2] = REG_WDATA;
				OFS_KEY4:  s_d.key[3] = REG_WDATA;
				default: begin
				end
			endcase
			// The low word of a pair holds bits 15-1, the high word bits 19-16.
			for (int w = 0; w < NUM_SCR; w++) begin
				if (REG_ADDR == OFS_SCR_START[w]) s_d.scr_start[w][15:0] = REG_WDATA & ADDR_LO_MASK;
				if (REG_ADDR == OFS_SCR_START[w] + OFS_PAIR_HI) s_d.scr_start[w][19:16] = REG_WDATA[3:0];
				if (REG_ADDR == OFS_SCR_END[w]) s_d.scr_end[w][15:0] = REG_WDATA & ADDR_LO_MASK;
				if (REG_ADDR == OFS_SCR_END[w] + OFS_PAIR_HI) s_d.scr_end[w][19:16] = REG_WDATA[3:0];
				if (REG_ADDR == OFS_DISP[w]) s_d.disp[w][15:0] = REG_WDATA & ADDR_LO_MASK;
				if (REG_ADDR == OFS_DISP[w] + OFS_PAIR_HI) s_d.disp[w][19:16] = REG_WDATA[3:0];
			end
		end
		if (REG_RE) begin
			s_d.rdata = 16'h0000;
			unique case (REG_ADDR)
				OFS_ORDER: s_d.rdata = 16'(s_q.order) << ORDER_LSB;
				OFS_CTRL:  s_d.rdata = s_q.ctrl;
				OFS_RATIO: s_d.rdata = s_q.ratio;
				OFS_TKEY1: s_d.rdata = s_q.tkey[0];
				OFS_TKEY2: s_d.rdata = s_q.tkey[1];
				OFS_KEY1:  s_d.rdata = s_q.key[0];
				OFS_KEY2:  s_d.rdata = s_q.key[1];
				OFS_KEY3:  s_d.rdata = s_q.key[2];
				OFS_KEY4:  s_d.rdata = s_q.key[3];
				default: begin
				end
			endcase
			for (int w = 0; w < NUM_SCR; w++) begin
				if (REG_ADDR == OFS_SCR_START[w]) s_d.rdata = s_q.scr_start[w][15:0];
				if (REG_ADDR == OFS_SCR_START[w] + OFS_PAIR_HI) s_d.rdata = {12'h000, s_q.scr_start[w][19:16]};
				if (REG_ADDR == OFS_SCR_END[w]) s_d.rdata = s_q.scr_end[w][15:0];
				if (REG_ADDR == OFS_SCR_END[w] + OFS_PAIR_HI) s_d.rdata = {12'h000, s_q.scr_end[w][19:16]};
				if (REG_ADDR == OFS_DISP[w]) s_d.rdata = s_q.disp[w][15:0];
				if (REG_ADDR == OFS_DISP[w] + OFS_PAIR_HI) s_d.rdata = {12'h000, s_q.disp[w][19:16]};
			end
		end
		// Only display reads walk these counters; host image writes use their own address path.
		for (int w = 0; w < NUM_SCR; w++) begin
			if (RD_FRAME[w]) begin
				s_d.rd_addr[w] = s_q.disp[w];
			end else if (RD_ADV[w]) begin
				s_d.rd_addr[w] = (sum[w] >= {1'b0, s_q.scr_end[w]}) ? s_q.scr_start[w] : sum[w][ADDR_W-1:0];
			end
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			s_q <= '{order: RST_ORDER, ctrl: RST_REG16, ratio: RST_REG16, tkey: '0, key: '0,
				scr_start: {NUM_SCR{RST_SCR_START}}, scr_end: {NUM_SCR{RST_SCR_END}},
				disp: {NUM_SCR{RST_DISP}}, rd_addr: {NUM_SCR{RST_DISP}}, rdata: RST_REG16};
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// Every property below runs on the system clock and sleeps through reset.
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);

	sequence s_ratio_wr;
		REG_WE && REG_ADDR == OFS_RATIO;
	endsequence
	sequence s_ratio_rd;
		REG_RE && !REG_WE && REG_ADDR == OFS_RATIO;
	endsequence
	sequence s_order_wr;
		REG_WE && REG_ADDR == OFS_ORDER;
	endsequence
	sequence s_ctrl_wr;
		REG_WE && REG_ADDR == OFS_CTRL;
	endsequence
	sequence s_disp_lo_wr;
		REG_WE && REG_ADDR == OFS_DISP[2];
	endsequence
	sequence s_adv0_plain;
		!RD_FRAME[0] && RD_ADV[0] && sum[0] < {1'b0, s_q.scr_end[0]};
	endsequence
	sequence s_wrap1;
		!RD_FRAME[1] && RD_ADV[1] && sum[1] >= {1'b0, s_q.scr_end[1]};
	endsequence
	sequence s_wrap2;
		!RD_FRAME[2] && RD_ADV[2] && sum[2] >= {1'b0, s_q.scr_end[2]};
	endsequence

	a_blend_order_gate: assert property (blend_sel |-> s_q.order[0] == 1'b0)
		else $error("blend selected while main layer is below overlays");
	a_blend_mode_gate: assert property (blend_sel |-> !s_q.ctrl[CTRL_MODE_BIT])
		else $error("blend selected with mode bit set");
	a_key_enable_used: assert property (blend_sel |-> s_q.ctrl[CTRL_KEN_LSB + hit_idx]
		&& PIX_MAIN == s_q.key[hit_idx])
		else $error("blend uses a disabled or unmatched key");
	a_ratio_clamp_full: assert property (blend_sel && ratio_raw >= RATIO_FULL |-> comp_pix == PIX_MAIN)
		else $error("full ratio does not return the main pixel");
	a_ratio_zero_pip: assert property (blend_sel && ratio_raw == 4'h0 |-> comp_pix == ov_pix)
		else $error("zero ratio does not return the overlay pixel");
	a_top_clear_bottom: assert property ((ov1_top ? ov1_clear : ov2_clear) && bot_cov |-> ov_pix == bot_pix)
		else $error("transparent top overlay still chosen");
	a_clear_not_shown: assert property (!main_top && (!PIX_OV1_HIT || ov1_clear)
		&& (!PIX_OV2_HIT || ov2_clear) |-> comp_pix == PIX_MAIN)
		else $error("transparent overlay pixel shown");
	a_frame_load_disp: assert property (RD_FRAME[0] |=> RD_ADDR[0] == $past(s_q.disp[0]))
		else $error("read address not loaded from display start");
	a_wrap_to_start: assert property (s_wrap1 |=> RD_ADDR[1] == $past(s_q.scr_start[1]))
		else $error("read address did not wrap to scroll start");
	a_ratio_readback: assert property (s_ratio_wr ##1 s_ratio_rd |=> REG_RDATA == $past(REG_WDATA, 2))
		else $error("ratio register read back differs from write");

	// Register fields land as written.
	a_order_field_write: assert property (s_order_wr |=> s_q.order == $past(REG_WDATA[ORDER_LSB +: 2]))
		else $error("order field not taken from the write");
	a_ctrl_field_write: assert property (s_ctrl_wr |=> s_q.ctrl == $past(REG_WDATA))
		else $error("control register not taken from the write");
	a_key_field_write: assert property (REG_WE && REG_ADDR == OFS_KEY1 |=> s_q.key[0] == $past(REG_WDATA))
		else $error("first key colour not taken from the write");
	a_tkey_field_write: assert property (REG_WE && REG_ADDR == OFS_TKEY2 |=> s_q.tkey[1] == $past(REG_WDATA))
		else $error("second transparent key not taken from the write");
	a_disp_lo_write: assert property (s_disp_lo_wr |=> s_q.disp[2][15:0] == ($past(REG_WDATA) & ADDR_LO_MASK))
		else $error("display start low word not taken from the write");

	// Composition outside the blend path.
	a_mode_set_main: assert property (main_top && s_q.ctrl[CTRL_MODE_BIT] |-> comp_pix == PIX_MAIN)
		else $error("mode bit set but main pixel not passed");
	a_overlay_top_shown: assert property (!main_top && top_cov |-> comp_pix == top_pix)
		else $error("visible top overlay pixel not shown");
	a_no_key_main: assert property (main_top && key_hit == '0 |-> comp_pix == PIX_MAIN)
		else $error("main pixel altered without a key match");

	// Read address walk of the second overlay window and the plain step.
	a_frame_load_win2: assert property (RD_FRAME[2] |=> RD_ADDR[2] == $past(s_q.disp[2]))
		else $error("second overlay read address not loaded from display start");
	a_wrap_win2: assert property (s_wrap2 |=> RD_ADDR[2] == $past(s_q.scr_start[2]))
		else $error("second overlay read address did not wrap");
	a_adv_no_wrap: assert property (s_adv0_plain |=> {1'b0, RD_ADDR[0]} == $past(sum[0]))
		else $error("read address did not advance by the step");
endmodule

// ===== verif/lbs_panel_model.sv
// Panel path sink model that takes composed pixels and can stall.
module lbs_panel_model (
	input  wire logic        clk,   // System clock.
	input  wire logic        stall, // Hold ready low while set.
	input  wire logic        valid, // Pixel offered.
	input  wire logic [15:0] data,  // Offered pixel.
	output      logic        ready  // Pixel taken at the next edge.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] got [$];
	assign ready = !stall;
	// Sampled at the falling edge, where registered outputs are settled.
	always @(negedge clk) begin
		if (valid === 1'b1 && ready)
			got.push_back(data);
	end
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the layer blend and scroll engine.
module tb_top
	import lbs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, reg_we, reg_re, pin_valid, pin_ready, pout_valid, pout_ready, h1, h2, stall;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, p_main, p_ov1, p_ov2, p_out, rd_step;
	logic [NUM_SCR-1:0] rd_frame, rd_adv;
	logic [NUM_SCR-1:0][ADDR_W-1:0] rd_addr;
	int n_errors, total_checks, k, w;
	logic [15:0] r;

	lbs_top dut (.CLK(clk), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WE(reg_we),
		.REG_RE(reg_re), .REG_RDATA(reg_rdata), .PIX_IN_VALID(pin_valid), .PIX_IN_READY(pin_ready),
		.PIX_MAIN(p_main), .PIX_OV1(p_ov1), .PIX_OV2(p_ov2), .PIX_OV1_HIT(h1), .PIX_OV2_HIT(h2),
		.PIX_OUT_VALID(pout_valid), .PIX_OUT_READY(pout_ready), .PIX_OUT(p_out), .RD_FRAME(rd_frame),
		.RD_ADV(rd_adv), .RD_STEP(rd_step), .RD_ADDR(rd_addr));
	lbs_panel_model pm (.clk(clk), .stall(stall), .valid(pout_valid), .data(p_out), .ready(pout_ready));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] kc(input int i);
		return 16'((i + 1) * 16'h1111);
	endfunction
	function automatic logic [15:0] mix(input logic [15:0] m, input logic [15:0] o, input int rc);
		int q;
		q = (rc > 8) ? 8 : rc;
		mix[15:11] = 5'((m[15:11] * q + o[15:11] * (8 - q)) >> 3);
		mix[10:5] = 6'((m[10:5] * q + o[10:5] * (8 - q)) >> 3);
		mix[4:0] = 5'((m[4:0] * q + o[4:0] * (8 - q)) >> 3);
	endfunction
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask
	task automatic wrrd(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'b0;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		#1;
		chk(reg_rdata, d);
	endtask
	task automatic push(input logic [15:0] m, input logic [15:0] o1, input logic [15:0] o2, input logic a, input logic b);
		int i;
		@(posedge clk);
		pin_valid <= 1'b1;
		p_main <= m;
		p_ov1 <= o1;
		p_ov2 <= o2;
		h1 <= a;
		h2 <= b;
		for (i = 0; i < 200; i++) begin
			@(negedge clk);
			if (pin_ready === 1'b1)
				break;
			@(posedge clk);
		end
		@(posedge clk);
		pin_valid <= 1'b0;
		if (i == 200) begin
			n_errors++;
			summarize();
		end
	endtask
	task automatic expect_pix(input logic [15:0] e);
		int i;
		for (i = 0; i < 200 && pm.got.size() == 0; i++)
			@(posedge clk);
		if (pm.got.size() == 0) begin
			n_errors++;
			summarize();
		end else
			chk(pm.got.pop_front(), e);
	endtask
	task automatic pulse(input logic fr, input int wi);
		@(posedge clk);
		if (fr)
			rd_frame <= 3'(1 << wi);
		else
			rd_adv <= 3'(1 << wi);
		@(posedge clk);
		rd_frame <= '0;
		rd_adv <= '0;
		#1;
	endtask

	// ------------------------------------------------------------
	// Clock and sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		{rstn, reg_we, reg_re, pin_valid, h1, h2, stall} = '0;
		{reg_addr, reg_wdata, p_main, p_ov1, p_ov2, rd_frame, rd_adv} = '0;
		rd_step = 16'h0004;
		n_errors = 0;
		total_checks = 0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		rd(OFS_CTRL, 16'h0000);
		rd(OFS_RATIO, 16'h0000);
		rd(OFS_SCR_END[0], 16'hfffe);
		rd(OFS_SCR_END[0] + OFS_PAIR_HI, 16'h000f);
		for (k = 0; k < NUM_KEYS; k++)
			wr(OFS_KEY1 + 16'(2 * k), kc(k));
		for (k = 0; k < NUM_KEYS; k++)
			rd(OFS_KEY1 + 16'(2 * k), kc(k));
		wrrd(OFS_RATIO, 16'h9503);
		wr(16'h0300, 16'h5a5a);
		rd(16'h0300, 16'h0000);
		$display("test registers done");
		// Each key alone, ratios 3, 0, 5 and the clipped code 9.
		wr(OFS_ORDER, 16'(ORDER_MAIN_TOP_A) << ORDER_LSB);
		for (k = 0; k < NUM_KEYS; k++) begin
			r = (16'h9503 >> (4 * k)) & 16'h000f;
			wr(OFS_CTRL, 16'h0001 << (CTRL_KEN_LSB + k));
			push(kc(k), 16'hf81f, 16'h0000, 1'b1, 1'b0);
			expect_pix(mix(kc(k), 16'hf81f, int'(r)));
		end
		wr(OFS_CTRL, 16'h0001 << CTRL_KEN_LSB);
		for (k = 0; k < 4; k++) begin
			wr(OFS_ORDER, 16'(k) << ORDER_LSB);
			push(kc(0), 16'hf81f, 16'h0000, 1'b1, 1'b0);
			expect_pix((k == 0 || k == 2) ? mix(kc(0), 16'hf81f, 3) : 16'hf81f);
		end
		wr(OFS_ORDER, 16'h0000);
		wr(OFS_CTRL, (16'h0001 << CTRL_KEN_LSB) | (16'h0001 << CTRL_MODE_BIT));
		push(kc(0), 16'hf81f, 16'h0000, 1'b1, 1'b0);
		expect_pix(kc(0));
		$display("test blending done");
		wr(OFS_TKEY1, 16'h0a0a);
		wr(OFS_TKEY2, 16'h0505);
		wr(OFS_CTRL, (16'h0001 << CTRL_KEN_LSB) | (16'h0001 << CTRL_TR1_BIT));
		wr(OFS_ORDER, 16'(ORDER_MAIN_TOP_B) << ORDER_LSB);
		push(kc(0), 16'h0a0a, 16'h07e0, 1'b1, 1'b1);
		expect_pix(mix(kc(0), 16'h07e0, 3));
		wr(OFS_ORDER, 16'h0003 << ORDER_LSB);
		push(16'h1234, 16'h0a0a, 16'h07e0, 1'b1, 1'b1);
		expect_pix(16'h07e0);
		wr(OFS_CTRL, (16'h0001 << CTRL_TR1_BIT) | (16'h0001 << CTRL_TR2_BIT));
		push(16'h1234, 16'h0a0a, 16'h0505, 1'b1, 1'b1);
		expect_pix(16'h1234);
		$display("test transparency done");
		wr(OFS_ORDER, 16'h0001 << ORDER_LSB);
		@(posedge clk);
		stall <= 1'b1;
		for (k = 0; k < FIFO_DEPTH; k++)
			push(16'h0100 + 16'(k), 16'h0000, 16'h0000, 1'b0, 1'b0);
		repeat (2) @(posedge clk);
		#1;
		chk(pin_ready, 1'b0);
		@(posedge clk);
		stall <= 1'b0;
		for (k = 0; k < FIFO_DEPTH; k++)
			expect_pix(16'h0100 + 16'(k));
		$display("test buffer done");
		// Start below end, both on line boundaries.
		for (w = 0; w < NUM_SCR; w++) begin
			wr(OFS_SCR_START[w], 16'h0100);
			wr(OFS_SCR_END[w], 16'h010c);
			wr(OFS_SCR_END[w] + OFS_PAIR_HI, 16'h0000);
			wr(OFS_DISP[w], 16'h0108);
			pulse(1'b1, w);
			chk(rd_addr[w], 20'h00108);
			pulse(1'b0, w);
			chk(rd_addr[w], 20'h00100);
			pulse(1'b0, w);
			chk(rd_addr[w], 20'h00104);
		end
		// Start zero and end at its largest value: the step to 10ch no longer wraps.
		wr(OFS_SCR_START[0], 16'h0000);
		wr(OFS_SCR_END[0], 16'hfffe);
		wr(OFS_SCR_END[0] + OFS_PAIR_HI, 16'h000f);
		pulse(1'b0, 0);
		chk(rd_addr[0], 20'h00108);
		pulse(1'b0, 0);
		chk(rd_addr[0], 20'h0010c);
		$display("test scroll done");
		summarize();
	end
endmodule
